// file: comparator_blanking_defs.svh
// Register offsets, field positions, reset values and counts for the comparator
// blanking and filter block. Assumes a 32-bit APB register bus with byte addresses.
`ifndef COMPARATOR_BLANKING_DEFS_SVH
`define COMPARATOR_BLANKING_DEFS_SVH

`define ADDR_WIDTH          8
`define OFF_SRC_SELECT      8'h00
`define OFF_GATE_CONTROL    8'h04
`define OFF_FILTER_CONTROL  8'h08
`define OFF_CHANNEL_CONTROL 8'h0c

`define RST_SRC_SELECT      16'h0000
`define RST_GATE_CONTROL    16'h0000
`define RST_FILTER_CONTROL  16'h0000

`define MASK_SRC_SELECT     16'h0fff
`define MASK_GATE_CONTROL   16'hbfff
`define MASK_FILTER_CONTROL 16'h007f

`define SRC_A_LSB           0
`define SRC_B_LSB           4
`define SRC_C_LSB           8
`define SRC_SEL_WIDTH       4
`define SRC_FAULT_TWO       4'he
`define SRC_FAULT_FOUR      4'hf

`define BIT_BLANK_LEVEL     15
`define BIT_OR_C_TRUE       13
`define BIT_OR_C_INV        12
`define BIT_OR_B_TRUE       11
`define BIT_OR_B_INV        10
`define BIT_OR_A_TRUE       9
`define BIT_OR_A_INV        8
`define BIT_AND_NEG_TO_OR   7
`define BIT_AND_POS_TO_OR   6
`define BIT_AND_C_TRUE      5
`define BIT_AND_C_INV       4
`define BIT_AND_B_TRUE      3
`define BIT_AND_B_INV       2
`define BIT_AND_A_TRUE      1
`define BIT_AND_A_INV       0

`define FLT_SEL_LSB         4
`define BIT_FILTER_EN       3
`define FLT_DIV_LSB         0

`define BIT_CMP_POLARITY    0
`define BIT_STAT_RAW        8
`define BIT_STAT_MASK       9
`define BIT_STAT_OUT        10

`define FILTER_HOLD_COUNT   2'd3
`define PIN_COUNT           24

`endif

// file: comparator_blanking_pkg.sv
// Types shared by the comparator blanking and filter design.
// Assumes the constants header is compiled alongside.
package comparator_blanking_pkg;

    typedef enum logic [2:0] {
        FCLK_PERIPHERAL = 3'b000,
        FCLK_OSCILLATOR = 3'b001,
        FCLK_SYNC_ONE   = 3'b010,
        FCLK_SYNC_TWO   = 3'b011,
        FCLK_TIMER2     = 3'b100,
        FCLK_TIMER3     = 3'b101,
        FCLK_TIMER4     = 3'b110,
        FCLK_TIMER5     = 3'b111
    } filter_clk_sel_type;

endpackage

// file: output_filter.sv
// Digital output filter: the output follows a new input level only after it has
// been seen on three consecutive sample ticks. Assumes ticks and data are on clk_sys.
`timescale 1ns/10ps
`include "comparator_blanking_defs.svh"

module output_filter
    import comparator_blanking_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rstSyncN,
    input  wire logic clkEn,
    input  wire logic filterEn,
    input  wire logic sampleTick,
    input  wire logic dataIn,
    output logic      dataOut
);

    logic [1:0] agreeCnt_q;

    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            agreeCnt_q <= 2'd0;
            dataOut    <= 1'b0;
        end else if (clkEn) begin
            if (!filterEn) begin
                agreeCnt_q <= 2'd0;
                dataOut    <= dataIn;
            end else if (sampleTick) begin
                if (dataIn == dataOut) begin
                    agreeCnt_q <= 2'd0;
                end else if (agreeCnt_q == `FILTER_HOLD_COUNT - 2'd1) begin
                    agreeCnt_q <= 2'd0;
                    dataOut    <= dataIn;
                end else begin
                    agreeCnt_q <= agreeCnt_q + 2'd1;
                end
            end
        end
    end

    default clocking fcb @(posedge clk_sys); endclocking
    default disable iff (!rstSyncN);

    filter_change_a: assert property (
        (clkEn && filterEn && dataOut != $past(dataOut) && $past(filterEn) && $past(clkEn))
        |-> ($past(agreeCnt_q) == 2'd2 && $past(sampleTick)))
        else $error("Filtered output changed before three agreeing samples.");

    filter_bypass_a: assert property (
        (clkEn && !filterEn) |=> (dataOut == $past(dataIn)))
        else $error("Disabled filter did not pass the input through.");

endmodule

// file: comparator_blanking.sv
// Blanking, gating, polarity and digital filter for one comparator channel,
// with an APB register slave. Assumes asynchronous pins for PWM, fault, comparator
// and filter clock sources; the peripheral clock is clk_sys itself.
`timescale 1ns/10ps
`include "comparator_blanking_defs.svh"

// Overview of operation
// - Source A selector code picks PWM low/high outputs, then fault two, four.
// - Sources B and C have own selectors with the same code mapping.
// - Blanking level bit sets the value held while the mask is active.
// - True-polarity enables add sources C, B, A to the mask OR gate.
// - Inverted-polarity enables add inverted sources C, B, A to the OR gate.
// - True-polarity enables add sources C, B, A to AND gate A1.
// - Inverted-polarity enables add inverted sources C, B, A to AND gate A1.
// - Negative AND select feeds inverted AND output into the OR gate.
// - Positive AND select feeds true AND output into the OR gate.
// - Filter clock select picks peripheral, oscillator, sync or timer clocks.
// - Filter enable passes the signal through the filter, else bypasses it.
// - Filter clock divider code n divides the selected clock by two to n.
// - Polarity select bit inverts the comparator output used downstream.
module comparator_blanking
    import comparator_blanking_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    reset_n,
    input  wire logic                    clkEn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`ADDR_WIDTH-1:0]  paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [6:0]              pwmGenLowOut,
    input  wire logic [6:0]              pwmGenHighOut,
    input  wire logic                    faultLineTwo,
    input  wire logic                    faultLineFour,
    input  wire logic                    cmpRawOut,
    input  wire logic                    oscillatorClock,
    input  wire logic                    pwmSyncOutOne,
    input  wire logic                    pwmSyncOutTwo,
    input  wire logic [3:0]              timerClock,
    output logic                         maskActive,
    output logic                         cmpOut
);

    logic                   rstMeta_q;
    logic                   rstSyncN;
    logic [`PIN_COUNT-1:0]  pinS1_q;
    logic [`PIN_COUNT-1:0]  pinS2_q;
    logic [`PIN_COUNT-1:0]  pinS3_q;
    logic [`PIN_COUNT-1:0]  pinStable_q;
    logic [15:0]            srcSelect_q;
    logic [15:0]            gateControl_q;
    logic [15:0]            filterControl_q;
    logic                   cmpPolarity_q;
    logic [15:0]            sourceVec;
    logic                   srcA;
    logic                   srcB;
    logic                   srcC;
    logic                   andOut;
    logic                   orOut;
    logic                   polarized;
    logic                   blanked_q;
    logic [6:0]             fltClkLevel;
    logic                   fltClkPrev_q;
    logic                   selClkTick;
    logic [6:0]             divCount_q;
    logic                   divTick;
    logic                   filterOut;
    logic                   accessWrite;
    filter_clk_sel_type     fltSel;
    logic [2:0]             fltDiv;

    // Address decode used only by the error answer; the read path decodes by its own case.
    function automatic logic isMapped(input logic [`ADDR_WIDTH-1:0] addr);
        return (addr == `OFF_SRC_SELECT) || (addr == `OFF_GATE_CONTROL) ||
               (addr == `OFF_FILTER_CONTROL) || (addr == `OFF_CHANNEL_CONTROL);
    endfunction

    // Selector shared by the three blanking sources.
    function automatic logic pickSource(input logic [3:0]  sel,
                                        input logic [15:0] vec);
        return vec[sel];
    endfunction

    // Divider terminal count for code n is two to the n, less one.
    function automatic logic [6:0] divLimit(input logic [2:0] code);
        return 7'((8'h01 << code) - 8'h01);
    endfunction

    // Reset is released through two flip-flops.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_q <= 1'b0;
            rstSyncN  <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSyncN  <= rstMeta_q;
        end
    end

    // Pin synchroniser: a change is accepted once the second and third stages agree.
    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pinS1_q     <= '0;
            pinS2_q     <= '0;
            pinS3_q     <= '0;
            pinStable_q <= '0;
        end else if (clkEn) begin
            pinS1_q     <= {timerClock, pwmSyncOutTwo, pwmSyncOutOne, oscillatorClock,
                            cmpRawOut, faultLineFour, faultLineTwo,
                            pwmGenHighOut, pwmGenLowOut};
            pinS2_q     <= pinS1_q;
            pinS3_q     <= pinS2_q;
            pinStable_q <= (pinS2_q & pinS3_q) | (pinStable_q & (pinS2_q ^ pinS3_q));
        end
    end

    // Synchronised sources laid out by selector code, low side on even codes.
    // source vector order
    always_comb begin
        sourceVec = 16'h0000;
        for (int k = 0; k < 7; k++) begin
            sourceVec[2*k]   = pinStable_q[k];
            sourceVec[2*k+1] = pinStable_q[7+k];
        end
        sourceVec[`SRC_FAULT_TWO]  = pinStable_q[14];
        sourceVec[`SRC_FAULT_FOUR] = pinStable_q[15];
    end

    assign fltClkLevel = pinStable_q[23:17];

    assign srcA = pickSource(srcSelect_q[`SRC_A_LSB +: 4], sourceVec);
    assign srcB = pickSource(srcSelect_q[`SRC_B_LSB +: 4], sourceVec);
    assign srcC = pickSource(srcSelect_q[`SRC_C_LSB +: 4], sourceVec);

    assign andOut = (!gateControl_q[`BIT_AND_A_TRUE] || srcA) &&
                    (!gateControl_q[`BIT_AND_B_TRUE] || srcB) &&
                    (!gateControl_q[`BIT_AND_C_TRUE] || srcC) &&
                    (!gateControl_q[`BIT_AND_A_INV]  || !srcA) &&
                    (!gateControl_q[`BIT_AND_B_INV]  || !srcB) &&
                    (!gateControl_q[`BIT_AND_C_INV]  || !srcC);

    assign orOut = (gateControl_q[`BIT_OR_A_TRUE] && srcA) ||
                   (gateControl_q[`BIT_OR_B_TRUE] && srcB) ||
                   (gateControl_q[`BIT_OR_C_TRUE] && srcC) ||
                   (gateControl_q[`BIT_OR_A_INV]  && !srcA) ||
                   (gateControl_q[`BIT_OR_B_INV]  && !srcB) ||
                   (gateControl_q[`BIT_OR_C_INV]  && !srcC) ||
                   (gateControl_q[`BIT_AND_NEG_TO_OR] && !andOut) ||
                   (gateControl_q[`BIT_AND_POS_TO_OR] && andOut);

    assign polarized = pinStable_q[16] ^ cmpPolarity_q;

    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            blanked_q  <= 1'b0;
            maskActive <= 1'b0;
        end else if (clkEn) begin
            blanked_q  <= orOut ? gateControl_q[`BIT_BLANK_LEVEL] : polarized;
            maskActive <= orOut;
        end
    end

    assign fltSel = filter_clk_sel_type'(filterControl_q[`FLT_SEL_LSB +: 3]);
    assign fltDiv = filterControl_q[`FLT_DIV_LSB +: 3];

    // Edge history of the selected synchronised filter clock.
    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            fltClkPrev_q <= 1'b0;
        end else if (clkEn) begin
            fltClkPrev_q <= (fltSel == FCLK_PERIPHERAL) ? 1'b0 : fltClkLevel[fltSel - 3'd1];
        end
    end

    always_comb begin
        unique case (fltSel)
            FCLK_PERIPHERAL: selClkTick = 1'b1;
            FCLK_OSCILLATOR,
            FCLK_SYNC_ONE,
            FCLK_SYNC_TWO,
            FCLK_TIMER2,
            FCLK_TIMER3,
            FCLK_TIMER4,
            FCLK_TIMER5:     selClkTick = fltClkLevel[fltSel - 3'd1] && !fltClkPrev_q;
        endcase
    end

    assign divTick = selClkTick && (divCount_q >= divLimit(fltDiv));

    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            divCount_q <= 7'h00;
        end else if (clkEn && selClkTick) begin
            divCount_q <= divTick ? 7'h00 : divCount_q + 7'h01;
        end
    end

    output_filter u_output_filter (
        .clk_sys    (clk_sys),
        .rstSyncN   (rstSyncN),
        .clkEn      (clkEn),
        .filterEn   (filterControl_q[`BIT_FILTER_EN]),
        .sampleTick (divTick),
        .dataIn     (blanked_q),
        .dataOut    (filterOut)
    );

    assign cmpOut = filterOut;

    // APB slave: zero wait states, error on an unmapped address.
    assign pready      = 1'b1;
    assign pslverr     = psel && penable && !isMapped(paddr);
    assign accessWrite = psel && penable && pwrite && clkEn;

    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            srcSelect_q     <= `RST_SRC_SELECT;
            gateControl_q   <= `RST_GATE_CONTROL;
            filterControl_q <= `RST_FILTER_CONTROL;
            cmpPolarity_q   <= 1'b0;
        end else if (accessWrite) begin
            unique case (paddr)
                `OFF_SRC_SELECT:      srcSelect_q     <= pwdata[15:0] & `MASK_SRC_SELECT;
                `OFF_GATE_CONTROL:    gateControl_q   <= pwdata[15:0] & `MASK_GATE_CONTROL;
                `OFF_FILTER_CONTROL:  filterControl_q <= pwdata[15:0] & `MASK_FILTER_CONTROL;
                `OFF_CHANNEL_CONTROL: cmpPolarity_q   <= pwdata[`BIT_CMP_POLARITY];
                default: ;
            endcase
        end
    end

    // Read data is captured in the setup cycle and held through the access cycle.
    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            prdata <= 32'h00000000;
        end else if (clkEn && psel && !penable) begin
            unique case (paddr)
                `OFF_SRC_SELECT:      prdata <= {16'h0000, srcSelect_q};
                `OFF_GATE_CONTROL:    prdata <= {16'h0000, gateControl_q};
                `OFF_FILTER_CONTROL:  prdata <= {16'h0000, filterControl_q};
                `OFF_CHANNEL_CONTROL: prdata <= {21'h000000, filterOut, maskActive,
                                                 pinStable_q[16], 7'h00, cmpPolarity_q};
                default:              prdata <= 32'h00000000;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstSyncN);

    src_a_fault_a: assert property (
        (srcSelect_q[3:0] == 4'he) |-> (srcA == pinStable_q[14]))
        else $error("Source A code 1110 does not follow fault line two.");

    src_a_pwm_a: assert property (
        (srcSelect_q[3:0] == 4'h3) |-> (srcA == pinStable_q[8]))
        else $error("Source A code 0011 does not follow generator two high.");

    src_b_c_a: assert property (
        (srcSelect_q[7:4] == 4'hf && srcSelect_q[11:8] == 4'h0)
        |-> (srcB == pinStable_q[15] && srcC == pinStable_q[0]))
        else $error("Source B or C selection mismatch.");

    blank_level_a: assert property (
        (clkEn && orOut) |=> (blanked_q == $past(gateControl_q[15]) && maskActive))
        else $error("Masked signal does not hold the blanking level.");

    or_true_a: assert property (
        (gateControl_q[13] && srcC) |-> orOut)
        else $error("Enabled true source C does not raise the mask.");

    or_inv_a: assert property (
        (gateControl_q[10] && !srcB) |-> orOut)
        else $error("Enabled inverted source B does not raise the mask.");

    and_true_a: assert property (
        (gateControl_q[1] && !srcA) |-> !andOut)
        else $error("AND gate high with a low enabled true input.");

    and_inv_a: assert property (
        (gateControl_q[4] && srcC) |-> !andOut)
        else $error("AND gate high with a high enabled inverted input.");

    and_neg_a: assert property (
        (gateControl_q[7] && !andOut) |-> orOut)
        else $error("Inverted AND output does not reach the OR gate.");

    and_pos_a: assert property (
        (gateControl_q[6] && andOut) |-> orOut)
        else $error("True AND output does not reach the OR gate.");

    mask_idle_a: assert property (
        (clkEn && gateControl_q[13:8] == 6'h00 && gateControl_q[7:6] == 2'b00)
        |=> (!maskActive && blanked_q == $past(polarized)))
        else $error("Mask active with no OR input enabled.");

    clk_sel_a: assert property (
        (filterControl_q[6:4] == 3'b000) |-> selClkTick)
        else $error("Peripheral clock selection does not tick every cycle.");

    div_count_a: assert property (
        (clkEn && $past(clkEn) && {filterControl_q[6:4], filterControl_q[2:0]} == 6'h01 &&
         $past({filterControl_q[6:4], filterControl_q[2:0]}) == 6'h01)
        |-> (divTick != $past(divTick)))
        else $error("Divide by two does not tick on every other cycle.");

    polarity_a: assert property (
        (clkEn && !orOut) |=> (blanked_q == ($past(pinStable_q[16]) ^ $past(cmpPolarity_q))))
        else $error("Polarity select does not invert the comparator.");

    mask_seen_c: cover property (clkEn && orOut ##1 maskActive);
    filter_on_c: cover property (filterControl_q[3] && divTick ##1 $changed(cmpOut));
    and_path_c:  cover property (gateControl_q[6] && andOut && gateControl_q[5:0] != 6'h00);
    div_max_c:   cover property (filterControl_q[2:0] == 3'b111 && divTick);

endmodule

// file: blank_source_model.sv
// Model of the PWM generators and fault lines that feed the blanking selectors.
// Assumes the bench sets the wanted level of each of the 16 sources on srcReq.
`timescale 1ns/10ps
module blank_source_model (
    input  wire logic        clk_sys,
    input  wire logic [15:0] srcReq,
    input  wire logic        slow,
    output logic [6:0]       pwmGenLowOut,
    output logic [6:0]       pwmGenHighOut,
    output logic             faultLineTwo,
    output logic             faultLineFour
);
    logic [15:0] stage = 16'h0000;
    logic [15:0] level = 16'h0000;
    // Slow generators change their outputs one clock later than prompt ones.
    always_ff @(posedge clk_sys) begin
        stage <= srcReq;
        level <= slow ? stage : srcReq;
    end
    always_comb begin
        for (int k = 0; k < 7; k++) begin
            pwmGenLowOut[k]  = level[2*k];
            pwmGenHighOut[k] = level[2*k+1];
        end
        faultLineTwo  = level[14];
        faultLineFour = level[15];
    end
endmodule

// file: tb_top.sv
// Self-checking bench for the comparator blanking and filter block.
// Assumes the design answers APB with no wait states and the constants header.
`timescale 1ns/10ps
`include "comparator_blanking_defs.svh"
module tb_top;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_type;
    logic        clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        slow = 0, cmpRawOut = 0, runClk = 0, lvl = 0, clkEn = 1;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, r;
    logic [15:0] srcReq = 0, g;
    logic [6:0]  fclk = 0;
    logic [1:0]  divCnt = 0;
    logic [31:0] prdata;
    logic        pready, pslverr, maskActive, cmpOut, f2, f4;
    logic [6:0]  pwmL, pwmH;
    note_type    noteQ[$];
    int          fail_count = 0, n_compared = 0, seed = 23, clkIdx = 0;

    comparator_blanking u_comparator_blanking (.clk_sys(clk_sys), .reset_n(reset_n),
        .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwmGenLowOut(pwmL), .pwmGenHighOut(pwmH), .faultLineTwo(f2), .faultLineFour(f4),
        .cmpRawOut(cmpRawOut), .oscillatorClock(fclk[0]), .pwmSyncOutOne(fclk[1]),
        .pwmSyncOutTwo(fclk[2]), .timerClock(fclk[6:3]), .maskActive(maskActive),
        .cmpOut(cmpOut));
    blank_source_model u_blank_source_model (.clk_sys(clk_sys), .srcReq(srcReq),
        .slow(slow), .pwmGenLowOut(pwmL), .pwmGenHighOut(pwmH), .faultLineTwo(f2),
        .faultLineFour(f4));

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    // The selected filter clock pin toggles every four system clocks while running.
    always @(posedge clk_sys) begin
        divCnt <= divCnt + 2'd1;
        if (runClk && divCnt == 2'd3) fclk[clkIdx] <= ~fclk[clkIdx];
    end

    task automatic report_and_stop;
        $display("Compared %0d, errors %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        n_compared++;
        if ((got & m) !== (exp & m)) begin
            fail_count++;
            $display("Error at %0t: read %h, expected %h", $time, got & m, exp & m);
        end
    endtask
    task automatic cmp_err(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: pslverr %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic cmp_pin(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: cmpOut/maskActive %b, expected %b", $time, got, exp);
        end
    endtask
    // Each completed transfer takes the oldest expectation off the queue.
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && noteQ.size() > 0) begin
            cmp_err(pslverr, noteQ[0].e);
            cmp_data(prdata, noteQ[0].d, noteQ[0].m);
            if (paddr == `OFF_CHANNEL_CONTROL && !pwrite)
                cmp_pin({cmpOut, maskActive}, noteQ[0].d[10:9]);
            void'(noteQ.pop_front());
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m);
        int n;
        noteQ.push_back(note_type'{d, m, a > `OFF_CHANNEL_CONTROL});
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
            if (n > 20) begin
                fail_count++;
                report_and_stop();
            end
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, e, m);
    endtask
    task automatic chk_status(input logic pol, input logic blank, input logic m, input logic raw);
        logic [31:0] e;
        e     = 32'h0;
        e[10] = m ? blank : raw ^ pol;
        e[9]  = m;
        e[0]  = pol;
        rd(`OFF_CHANNEL_CONTROL, e, 32'h0000_0601);
    endtask
    function automatic logic mask_exp(logic [15:0] gc, logic a, logic b, logic c);
        logic andOut;
        andOut = (!gc[1] | a) & (!gc[0] | !a) & (!gc[3] | b) & (!gc[2] | !b)
               & (!gc[5] | c) & (!gc[4] | !c);
        return (gc[9] & a) | (gc[8] & !a) | (gc[11] & b) | (gc[10] & !b) | (gc[13] & c)
             | (gc[12] & !c) | (gc[6] & andOut) | (gc[7] & !andOut);
    endfunction

    initial begin
        logic [7:0]  offs [3];
        logic [31:0] msks [3];
        offs = '{`OFF_SRC_SELECT, `OFF_GATE_CONTROL, `OFF_FILTER_CONTROL};
        msks = '{32'h0fff, 32'hbfff, 32'h007f};
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 3; i++) rd(offs[i], 32'h0, 32'hffff_ffff);
        rd(`OFF_CHANNEL_CONTROL, 32'h0, 32'hffff_ffff);
        wr(8'h10, 32'hffff_ffff);
        rd(8'h10, 32'h0, 32'hffff_ffff);
        for (int i = 0; i < 3; i++) begin
            wr(offs[i], 32'hffff_ffff);
            rd(offs[i], msks[i], 32'hffff_ffff);
            wr(offs[i], 32'h0);
        end
        for (int s = 0; s < 3; s++) begin
            wr(`OFF_GATE_CONTROL, 32'h1 << (9 + 2 * s));
            for (int c = 0; c < 16; c++) begin
                wr(`OFF_SRC_SELECT, c << (4 * s));
                srcReq <= 16'h1 << c;
                repeat (10) @(posedge clk_sys);
                chk_status(1'b0, 1'b0, 1'b1, 1'b0);
                srcReq <= ~(16'h1 << c);
                repeat (10) @(posedge clk_sys);
                chk_status(1'b0, 1'b0, 1'b0, 1'b0);
            end
        end
        wr(`OFF_SRC_SELECT, 32'h0e83);
        for (int i = 0; i < 48; i++) begin
            r = $random(seed);
            g = r[15:0] & 16'hbfff;
            wr(`OFF_GATE_CONTROL, {16'h0, g});
            wr(`OFF_CHANNEL_CONTROL, {31'h0, r[16]});
            srcReq    <= r[31:16];
            cmpRawOut <= r[17];
            slow      <= r[18];
            repeat (10) @(posedge clk_sys);
            chk_status(r[16], g[15], mask_exp(g, srcReq[3], srcReq[8], srcReq[14]), r[17]);
        end
        wr(`OFF_GATE_CONTROL, 32'h0);
        wr(`OFF_CHANNEL_CONTROL, 32'h0);
        lvl = cmpRawOut;
        for (int n = 0; n < 8; n++) begin
            wr(`OFF_FILTER_CONTROL, 32'h8 | n);
            lvl = ~lvl;
            cmpRawOut <= lvl;
            repeat (2 * (1 << n) + 2) @(posedge clk_sys);
            chk_status(1'b0, 1'b0, 1'b0, ~lvl);
            repeat (4 * (1 << n) + 8) @(posedge clk_sys);
            chk_status(1'b0, 1'b0, 1'b0, lvl);
        end
        wr(`OFF_FILTER_CONTROL, 32'h8);
        cmpRawOut <= ~lvl;
        repeat (2) @(posedge clk_sys);
        cmpRawOut <= lvl;
        repeat (12) @(posedge clk_sys);
        chk_status(1'b0, 1'b0, 1'b0, lvl);
        for (int k = 1; k < 8; k++) begin
            clkIdx = k - 1;
            wr(`OFF_FILTER_CONTROL, 32'h8 | (k << 4));
            lvl = ~lvl;
            cmpRawOut <= lvl;
            repeat (40) @(posedge clk_sys);
            chk_status(1'b0, 1'b0, 1'b0, ~lvl);
            runClk <= 1'b1;
            repeat (60) @(posedge clk_sys);
            chk_status(1'b0, 1'b0, 1'b0, lvl);
            runClk <= 1'b0;
        end
        // With the clock enable low the bypassed output must not follow the pin.
        wr(`OFF_FILTER_CONTROL, 32'h0);
        clkEn     <= 1'b0;
        cmpRawOut <= ~lvl;
        repeat (12) @(posedge clk_sys);
        cmp_pin({cmpOut, maskActive}, {lvl, 1'b0});
        clkEn <= 1'b1;
        repeat (12) @(posedge clk_sys);
        cmp_pin({cmpOut, maskActive}, {~lvl, 1'b0});
        report_and_stop();
    end
endmodule
